/* File: core/sscp_pkg.sv */
// Shared constants and types of the serial slave command port
package sscp_pkg;

  // Core clock rate and nonvolatile store time
  localparam int CLK_FREQ_KHZ        = 10000;
  localparam int NV_STORE_TIME_MS    = 10;
  localparam int NV_STORE_CYCLES_DEF = NV_STORE_TIME_MS * CLK_FREQ_KHZ;
  localparam int NV_CNT_W            = 17;

  // Input filter depth in core cycles
  localparam int FILT_LEN = 3;

  // Command codes selecting a register or an action
  localparam logic [7:0] CMD_DAC      = 8'h08;
  localparam logic [7:0] CMD_OFFSET   = 8'h0e;
  localparam logic [7:0] CMD_DIV      = 8'h01;
  localparam logic [7:0] CMD_MUX      = 8'h02;
  localparam logic [7:0] CMD_ADDR     = 8'h0d;
  localparam logic [7:0] CMD_RANGE    = 8'h37;
  localparam logic [7:0] CMD_NV_STORE = 8'h3f;

  // Field positions inside the device-address register
  localparam int ADDR_WC_BIT  = 3;
  localparam int ADDR_SEL_MSB = 2;

  // Reset values of the working registers
  localparam logic [9:0] DAC_RST    = 10'h000;
  localparam logic [4:0] OFFSET_RST = 5'h00;
  localparam logic [9:0] DIV_RST    = 10'h000;
  localparam logic [9:0] MUX_RST    = 10'h000;
  localparam logic [3:0] ADDR_RST   = 4'h0;

  // Fill values for unused read bits
  localparam logic [2:0] OFFSET_FILL = 3'h7;
  localparam logic [7:0] READ_PAD    = 8'h00;

  // Working register image, also the image sent to nonvolatile memory
  typedef struct packed {
    logic [9:0] dac_word;
    logic [4:0] offset_word;
    logic [9:0] div_word;
    logic [9:0] output_select_word;
    logic [3:0] addr_word;
  } sscp_regs_type;

  // Serial line activity after filtering
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } sscp_line_type;

endpackage

/* File: core/sscp_slave.sv */
`timescale 1ns/1ns
// Operation
// - Range read: high eight, then five low bits
// - Range register read-only, writes ignored
// - Store command with write-control set stores all
// - Write-control clear: auto-store after register writes
// - Device-address write always stores
// - START: data falls while clock high
// - STOP: data rises while clock high
// - Data changes only while clock low
// - Eight-bit bytes plus acknowledge, unlimited count
// - Works at standard and fast rates
// - Acknowledge held low through clock high
// - Not-acknowledge everything while store runs
// - Master not-acknowledge: release data line
// - Repeated START restarts control byte reception
// - Read direction: device transmits on data
// - Control byte: type, three select, direction
// - Select defaults zero, follows written value
// - Direction one reads, zero writes
// - Acknowledge control byte only on full match
// - Acknowledge every received write byte
// - Command byte first, restart for reads
// - Write-control bit beside select bits, default zero
// - Busy window lasts until store completes
module sscp_slave
  import sscp_pkg::*;
#(
  parameter int         NV_STORE_CYCLES = NV_STORE_CYCLES_DEF, // Store duration
  parameter logic [3:0] TYPE_CODE       = 4'h5                 // Arbitrary value
) (
  input  wire logic          i_core_clk,          // Core clock
  input  wire logic          i_rst,               // Synchronous reset
  input  wire logic          i_scl,               // Serial clock pin
  input  wire logic          i_sda,               // Serial data pin level
  output logic               o_sda_out,           // Data pin drive value
  output logic               o_sda_oe,            // Data pin pulled low
  input  wire logic [13:0]   i_default_offset_code, // Factory range value
  output sscp_regs_type      o_regs,              // Working registers
  output sscp_regs_type      o_nv_image,          // Image being stored
  output logic               o_nv_store,          // Store start pulse
  output logic               o_nv_busy            // Store in progress
);

  // Bus transfer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } sscp_state_type;

  // Meaning of the byte being received
  typedef enum logic [1:0] {
    ROLE_CTRL,
    ROLE_CMD,
    ROLE_DATA
  } sscp_role_type;

  // Synchronisers and filters
  logic [1:0]          scl_sync_reg;     // Two-stage clock sync
  logic [1:0]          sda_sync_reg;     // Two-stage data sync
  logic [FILT_LEN-1:0] scl_hist_reg;     // Recent clock samples
  logic [FILT_LEN-1:0] sda_hist_reg;     // Recent data samples
  logic                scl_filt_reg;     // Filtered clock
  logic                sda_filt_reg;     // Filtered data
  sscp_line_type       line;             // Decoded line events

  // Protocol state
  sscp_state_type      state_reg;        // Transfer state
  sscp_role_type       role_reg;         // Current byte role
  logic [3:0]          bit_cnt_reg;      // Bits of current byte
  logic [7:0]          shift_reg;        // Receive and transmit shifter
  logic                read_mode_reg;    // Transfer is a read
  logic [7:0]          cmd_reg;          // Last command byte
  logic                byte_idx_reg;     // Data byte within command
  logic                sda_drive_reg;    // Pulling data line low
  logic                master_ack_reg;   // Master acknowledged last byte

  // Registers and store control
  sscp_regs_type       regs_reg;         // Working registers
  sscp_regs_type       nv_image_reg;     // Snapshot for the store
  logic                store_pend_reg;   // Store due at end of transfer
  logic                nv_store_reg;     // Store start pulse
  logic [NV_CNT_W-1:0] nv_cnt_reg;       // Store time left

  // Synchronise pin inputs through two flops
  always_ff @(posedge i_core_clk) begin
    scl_sync_reg <= {scl_sync_reg[0], i_scl};
    sda_sync_reg <= {sda_sync_reg[0], i_sda};
  end

  // Shift history of the second sync stage only
  always_ff @(posedge i_core_clk) begin
    scl_hist_reg <= {scl_hist_reg[FILT_LEN-2:0], scl_sync_reg[1]};
    sda_hist_reg <= {sda_hist_reg[FILT_LEN-2:0], sda_sync_reg[1]};
  end

  // Filtered level changes only when all samples agree
  wire scl_all_hi = &scl_hist_reg;
  wire scl_all_lo = ~|scl_hist_reg;
  wire sda_all_hi = &sda_hist_reg;
  wire sda_all_lo = ~|sda_hist_reg;
  wire scl_filt_next = scl_all_hi ? 1'b1 : (scl_all_lo ? 1'b0 : scl_filt_reg);
  wire sda_filt_next = sda_all_hi ? 1'b1 : (sda_all_lo ? 1'b0 : sda_filt_reg);

  // Filter stage, idles high like the bus
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      scl_filt_reg <= 1'b1;
      sda_filt_reg <= 1'b1;
    end else begin
      scl_filt_reg <= scl_filt_next;
      sda_filt_reg <= sda_filt_next;
    end
  end

  // Line events; edges at 400 kHz span many core cycles
  assign line.scl_rise = scl_filt_next & ~scl_filt_reg;
  assign line.scl_fall = ~scl_filt_next & scl_filt_reg;
  assign line.start    = scl_filt_reg & scl_filt_next
                         & sda_filt_reg & ~sda_filt_next;
  assign line.stop     = scl_filt_reg & scl_filt_next
                         & ~sda_filt_reg & sda_filt_next;
  assign line.sda      = sda_filt_next;

  // Received byte decode
  wire [7:0] rx_byte   = shift_reg;
  wire       byte_done = (bit_cnt_reg == 4'h8);
  wire       busy      = (nv_cnt_reg != '0);
  wire [2:0] my_select = regs_reg.addr_word[ADDR_SEL_MSB:0];
  wire       wc_set    = regs_reg.addr_word[ADDR_WC_BIT];
  wire       ctrl_match = (rx_byte[7:4] == TYPE_CODE)
                          && (rx_byte[3:1] == my_select);
  wire       ack_ctrl  = ctrl_match & ~busy;
  wire       rx_ack    = (role_reg == ROLE_CTRL) ? ack_ctrl : ~busy;

  // Writable command codes
  wire cmd_wide = (cmd_reg == CMD_DAC) || (cmd_reg == CMD_DIV)
                  || (cmd_reg == CMD_MUX);
  wire cmd_writable = cmd_wide || (cmd_reg == CMD_OFFSET)
                      || (cmd_reg == CMD_ADDR);
  wire data_write = (role_reg == ROLE_DATA) & cmd_writable & ~busy;

  // Store request from a finished command or data byte
  wire req_cmd_store = (role_reg == ROLE_CMD) & (rx_byte == CMD_NV_STORE)
                       & wc_set & ~busy;
  wire req_auto = data_write & (~wc_set | (cmd_reg == CMD_ADDR));

  // Read data for the current command and byte index
  wire [13:0] range_v = i_default_offset_code;
  // Low part selected already in the gap before the second byte is loaded
  wire        tx_second = (state_reg == ST_TXACK) | byte_idx_reg;
  logic [7:0] tx_byte;
  always_comb begin
    tx_byte = READ_PAD;
    case (cmd_reg)
      CMD_DAC:    tx_byte = tx_second ? {regs_reg.dac_word[1:0], 6'h00}
                                      : regs_reg.dac_word[9:2];
      CMD_DIV:    tx_byte = tx_second ? {regs_reg.div_word[1:0], 6'h00}
                                      : regs_reg.div_word[9:2];
      CMD_MUX:    tx_byte = tx_second
                            ? {regs_reg.output_select_word[1:0], 6'h00}
                            : regs_reg.output_select_word[9:2];
      CMD_OFFSET: tx_byte = {OFFSET_FILL, regs_reg.offset_word};
      CMD_ADDR:   tx_byte = {4'h0, regs_reg.addr_word};
      CMD_RANGE:  tx_byte = tx_second ? {range_v[4:0], 3'h0}
                                      : range_v[13:6];
      default:    tx_byte = READ_PAD;
    endcase
  end

  // Byte receive, acknowledge and transmit sequencing
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg      <= ST_IDLE;
      role_reg       <= ROLE_CTRL;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      read_mode_reg  <= 1'b0;
      cmd_reg        <= 8'h00;
      byte_idx_reg   <= 1'b0;
      sda_drive_reg  <= 1'b0;
      master_ack_reg <= 1'b0;
    end else if (line.start) begin
      // Start or repeated start: expect a control byte
      state_reg     <= ST_RX;
      role_reg      <= ROLE_CTRL;
      bit_cnt_reg   <= 4'h0;
      sda_drive_reg <= 1'b0;
    end else if (line.stop) begin
      // Stop ends any transfer
      state_reg     <= ST_IDLE;
      sda_drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_RX: begin
          // Sample on rise, decide on the fall after the eighth bit
          if (line.scl_rise && !byte_done) begin
            shift_reg   <= {shift_reg[6:0], line.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (line.scl_fall && byte_done) begin
            bit_cnt_reg <= 4'h0;
            if (rx_ack) begin
              state_reg     <= ST_ACK;
              sda_drive_reg <= 1'b1;
              if (role_reg == ROLE_CTRL) begin
                read_mode_reg <= rx_byte[0];
                byte_idx_reg  <= 1'b0;
              end else if (role_reg == ROLE_CMD) begin
                cmd_reg      <= rx_byte;
                byte_idx_reg <= 1'b0;
              end else begin
                byte_idx_reg <= 1'b1;
              end
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          // Release after the acknowledge pulse, or drive the first bit of a read
          if (line.scl_fall) begin
            if ((role_reg == ROLE_CTRL) && read_mode_reg) begin
              state_reg     <= ST_TX;
              shift_reg     <= tx_byte;
              sda_drive_reg <= ~tx_byte[7];
            end else begin
              state_reg     <= ST_RX;
              sda_drive_reg <= 1'b0;
              role_reg      <= (role_reg == ROLE_CTRL) ? ROLE_CMD : ROLE_DATA;
            end
          end
        end
        ST_TX: begin
          // Shift next bit out while the clock is low
          if (line.scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              bit_cnt_reg   <= 4'h0;
              state_reg     <= ST_TXACK;
              sda_drive_reg <= 1'b0;
            end else begin
              bit_cnt_reg   <= bit_cnt_reg + 4'h1;
              shift_reg     <= {shift_reg[6:0], 1'b0};
              sda_drive_reg <= ~shift_reg[6];
            end
          end
        end
        ST_TXACK: begin
          // Master answer sampled on rise, acted on at fall
          if (line.scl_rise) begin
            master_ack_reg <= ~line.sda;
          end else if (line.scl_fall) begin
            if (master_ack_reg) begin
              state_reg     <= ST_TX;
              shift_reg     <= byte_idx_reg ? READ_PAD : tx_byte;
              sda_drive_reg <= byte_idx_reg ? ~READ_PAD[7] : ~tx_byte[7];
              byte_idx_reg  <= 1'b1;
            end else begin
              state_reg     <= ST_IDLE;
              sda_drive_reg <= 1'b0;
            end
          end
        end
        default: begin
          // Idle: line released until next START
          sda_drive_reg <= 1'b0;
        end
      endcase
    end
  end

  // Register write strobe at the end of each accepted data byte to a writable command
  wire wr_strobe = (state_reg == ST_RX) & line.scl_fall & byte_done
                   & ~line.start & ~line.stop & data_write;
  wire cmd_strobe = (state_reg == ST_RX) & line.scl_fall & byte_done
                    & ~line.start & ~line.stop & req_cmd_store;
  wire wide_hi = cmd_wide & ~byte_idx_reg;

  // Working register updates
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      regs_reg.dac_word           <= DAC_RST;
      regs_reg.offset_word        <= OFFSET_RST;
      regs_reg.div_word           <= DIV_RST;
      regs_reg.output_select_word <= MUX_RST;
      regs_reg.addr_word          <= ADDR_RST;
    end else if (wr_strobe) begin
      case (cmd_reg)
        CMD_DAC: begin
          if (wide_hi) regs_reg.dac_word[9:2] <= rx_byte;
          else regs_reg.dac_word[1:0] <= rx_byte[7:6];
        end
        CMD_DIV: begin
          if (wide_hi) regs_reg.div_word[9:2] <= rx_byte;
          else regs_reg.div_word[1:0] <= rx_byte[7:6];
        end
        CMD_MUX: begin
          if (wide_hi) regs_reg.output_select_word[9:2] <= rx_byte;
          else regs_reg.output_select_word[1:0] <= rx_byte[7:6];
        end
        CMD_OFFSET: regs_reg.offset_word <= rx_byte[4:0];
        CMD_ADDR:   regs_reg.addr_word   <= rx_byte[3:0];
        default:    regs_reg.offset_word <= regs_reg.offset_word;
      endcase
    end
  end

  // Store launches when the transfer ends
  wire xfer_end = (line.stop | line.start) & store_pend_reg & ~busy;

  // Pending store flag; a new request wins over the launch clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      store_pend_reg <= 1'b0;
    end else if ((wr_strobe & req_auto) | cmd_strobe) begin
      store_pend_reg <= 1'b1;
    end else if (xfer_end) begin
      store_pend_reg <= 1'b0;
    end
  end

  // Store timer, snapshot and start pulse
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      nv_cnt_reg   <= '0;
      nv_store_reg <= 1'b0;
      nv_image_reg <= '0;
    end else begin
      nv_store_reg <= xfer_end;
      if (xfer_end) begin
        nv_cnt_reg   <= NV_CNT_W'(NV_STORE_CYCLES);
        nv_image_reg <= regs_reg;
      end else if (busy) begin
        nv_cnt_reg <= nv_cnt_reg - NV_CNT_W'(1);
      end
    end
  end

  // Outputs
  assign o_sda_out  = 1'b0;
  assign o_sda_oe   = sda_drive_reg;
  assign o_regs     = regs_reg;
  assign o_nv_image = nv_image_reg;
  assign o_nv_store = nv_store_reg;
  assign o_nv_busy  = busy;

endmodule

/* File: test/sscp_chk.sv */
`timescale 1ns/1ns
// Port checker for the serial slave command port
module sscp_chk
  import sscp_pkg::*;
#(
  parameter int NV_STORE_CYCLES = 300 // Store duration
) (
  input wire logic          i_core_clk,
  input wire logic          i_rst,
  input wire logic          i_scl,
  input wire logic          i_sda,
  input wire logic          o_sda_out,
  input wire logic          o_sda_oe,
  input wire logic [13:0]   i_default_offset_code,
  input wire sscp_regs_type o_regs,
  input wire sscp_regs_type o_nv_image,
  input wire logic          o_nv_store,
  input wire logic          o_nv_busy
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic [16:0] busy_cnt_reg; // Length of the running busy window
  // Count busy cycles, cleared while idle
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !o_nv_busy) begin
      busy_cnt_reg <= '0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 17'h1;
    end
  end
  drv_zero_a: assert property (o_sda_out == 1'b0)
    else $error("data drive value not zero");
  edge_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  busy_ack_a: assert property (o_nv_busy |-> !$rose(o_sda_oe))
    else $error("acknowledge driven while storing");
  busy_regs_a: assert property (o_nv_busy && $past(o_nv_busy, 2) |-> $stable(o_regs))
    else $error("registers changed while storing");
  store_busy_a: assert property (o_nv_store |-> ##1 o_nv_busy [*8])
    else $error("busy missing after store");
  store_once_a: assert property (o_nv_store |-> !$past(o_nv_busy) ##1 !o_nv_store)
    else $error("store pulse while busy or too long");
  busy_len_a: assert property ($fell(o_nv_busy) |->
      busy_cnt_reg >= NV_STORE_CYCLES - 1 && busy_cnt_reg <= NV_STORE_CYCLES + 1)
    else $error("busy window length wrong");
  image_hold_a: assert property (o_nv_busy && $past(o_nv_busy, 2) |-> $stable(o_nv_image))
    else $error("store image changed while storing");
  rst_val_a: assert property ($fell(i_rst) |-> o_regs == '0 && !o_nv_busy && !o_sda_oe)
    else $error("reset values wrong");
  cover property (o_nv_store);
  cover property ($rose(o_sda_oe));
  cover property ($fell(o_nv_busy));
endmodule
bind sscp_slave sscp_chk #(.NV_STORE_CYCLES(NV_STORE_CYCLES)) chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_default_offset_code(i_default_offset_code),
  .o_regs(o_regs), .o_nv_image(o_nv_image), .o_nv_store(o_nv_store), .o_nv_busy(o_nv_busy));

/* File: test/sscp_master_model.sv */
`timescale 1ns/1ns
// Two-wire bus master, open-drain data, clock idle high between frames
module sscp_master_model (
  input  wire logic       i_sda,     // Resolved data wire
  output logic            o_scl,     // Serial clock
  output logic            o_sda_oe,  // High pulls data low
  output logic [8:0]      o_res,     // Ack bit and byte seen on the wire
  output logic            o_res_tgl  // Toggles once per byte
);
  // Bus starts idle, both lines high
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    o_res = '0;
    o_res_tgl = 1'b0;
  end
  // START from idle, or repeated START from clock low
  // Full low time first, so the device has dropped its acknowledge
  task automatic start();
    o_sda_oe <= 1'b0;
    #800 o_scl <= 1'b1;
    #400 o_sda_oe <= 1'b1;
    #400 o_scl <= 1'b0;
  endtask
  // STOP after a full low time, then bus free time
  task automatic stop();
    #100 o_sda_oe <= 1'b1;
    #700 o_scl <= 1'b1;
    #400 o_sda_oe <= 1'b0;
    #800;
  endtask
  // One bit: data set in clock low, sampled in clock high
  task automatic bit_io(input logic b, output logic r);
    #100 o_sda_oe <= !b;
    #700 o_scl <= 1'b1;
    #400 r = i_sda;
    #400 o_scl <= 1'b0;
  endtask
  // Eight bits MSB first, then the ninth acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic a);
    logic [8:0] r;
    logic       bv;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], bv);
      r[i] = bv;
    end
    bit_io(a, bv);
    r[8] = bv;
    o_res = r;
    o_res_tgl = !o_res_tgl;
  endtask
endmodule

/* File: test/sscp_slave_tb.sv */
`timescale 1ns/1ns
// Self-checking bench for the serial slave command port
module sscp_slave_tb
  import sscp_pkg::*;
;
  localparam int         NVC = 300;  // Shortened store time
  localparam logic [3:0] TC  = 4'h5; // Arbitrary type code
  logic          clk;      // Core clock
  logic          rst;      // Synchronous reset
  logic          scl;      // Serial clock from master
  logic          m_oe;     // Master pulls data low
  logic          d_oe;     // Device pulls data low
  logic          d_out;    // Device drive value
  logic [13:0]   rng;      // Range register value
  sscp_regs_type regs;     // Working registers
  sscp_regs_type img;      // Image being stored
  sscp_regs_type shd;      // Expected registers
  logic          nv_st;    // Store pulse
  logic          nv_busy;  // Store busy
  logic [8:0]    res;      // Ack and byte on the wire
  logic          res_tgl;  // Byte event
  logic [8:0]    bq[$];    // Expected bytes
  sscp_regs_type sq[$];    // Expected store images
  int            err_count;
  int            n_compared;
  wire           sda = !(m_oe || d_oe); // Pulled-up wire
  sscp_slave #(.NV_STORE_CYCLES(NVC), .TYPE_CODE(TC)) uut (
    .i_core_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(d_out),
    .o_sda_oe(d_oe), .i_default_offset_code(rng), .o_regs(regs), .o_nv_image(img),
    .o_nv_store(nv_st), .o_nv_busy(nv_busy));
  sscp_master_model m (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe), .o_res(res),
    .o_res_tgl(res_tgl));
  // Core clock, 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [38:0] seen, input logic [38:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Byte from master; nak set where the device must stay off the line
  task automatic wb(input logic [7:0] d, input logic nak);
    bq.push_back({nak, d});
    m.xfer(d, 1'b1);
  endtask
  // Byte from device, master acks unless last
  task automatic rb(input logic [7:0] e, input logic last);
    bq.push_back({last, e});
    m.xfer(8'hff, last);
  endtask
  // Register write with n data bytes
  task automatic wr(input logic [2:0] s, input logic [7:0] c, input logic [7:0] b0,
                    input logic [7:0] b1, input int n);
    m.start();
    wb({TC, s, 1'b0}, 1'b0);
    wb(c, 1'b0);
    if (n > 0) wb(b0, 1'b0);
    if (n > 1) wb(b1, 1'b0);
    m.stop();
  endtask
  // Two-byte register read through repeated START
  task automatic rd(input logic [2:0] s, input logic [7:0] c, input logic [7:0] e0,
                    input logic [7:0] e1);
    m.start();
    wb({TC, s, 1'b0}, 1'b0);
    wb(c, 1'b0);
    m.start();
    wb({TC, s, 1'b1}, 1'b0);
    rb(e0, 1'b0);
    rb(e1, 1'b1);
    m.stop();
  endtask
  // Control byte that must be refused
  task automatic refuse(input logic [7:0] ctl);
    m.start();
    wb(ctl, 1'b1);
    wb(8'h01, 1'b1);
    m.stop();
  endtask
  // Byte results against oldest expectation
  always @(res_tgl) begin
    if ($time > 0) check(39'(res), 39'(bq.pop_front()));
  end
  // Store image against oldest expectation, read once it has settled
  always @(posedge clk) begin
    if (nv_st === 1'b1) begin
      @(posedge clk);
      if (sq.size() == 0) check(39'h1, 39'h0);
      else check(img, sq.pop_front());
    end
  end
  // Watchdog
  initial begin
    #4000000;
    err_count++;
    stop_test();
  end
  // Main sequence
  initial begin
    logic [9:0]  v;
    logic [9:0]  w;
    logic [13:0] r;
    err_count = 0;
    n_compared = 0;
    rst = 1'b1;
    rng = '0;
    shd = '0;
    void'($urandom(98426));
    v = 10'($urandom);
    w = 10'($urandom);
    r = 14'($urandom);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rng <= r;
    repeat (10) @(posedge clk);
    // Wide write auto-stores, then busy refuses, then resumes
    shd.div_word = v;
    sq.push_back(shd);
    wr(3'h0, CMD_DIV, v[9:2], {v[1:0], 6'h2a}, 2);
    refuse({TC, 3'h0, 1'b0});
    repeat (NVC + 20) @(posedge clk);
    rd(3'h0, CMD_DIV, v[9:2], {v[1:0], 6'h00});
    rd(3'h0, CMD_RANGE, r[13:6], {r[4:0], 3'h0});
    // Foreign type code and foreign select
    refuse({~TC, 3'h0, 1'b0});
    refuse({TC, 3'h4, 1'b0});
    // Address write stores always and moves the select
    shd.addr_word = 4'hb;
    sq.push_back(shd);
    wr(3'h0, CMD_ADDR, 8'hfb, 8'h00, 1);
    repeat (NVC + 20) @(posedge clk);
    refuse({TC, 3'h0, 1'b0});
    // Write-control set: stores wait for the store command
    shd.dac_word = w;
    wr(3'h3, CMD_DAC, w[9:2], {w[1:0], 6'h15}, 2);
    wr(3'h3, CMD_RANGE, 8'h00, 8'h00, 1);
    repeat (NVC) @(posedge clk);
    sq.push_back(shd);
    wr(3'h3, CMD_NV_STORE, 8'h00, 8'h00, 0);
    repeat (NVC + 20) @(posedge clk);
    rd(3'h3, CMD_RANGE, r[13:6], {r[4:0], 3'h0});
    rd(3'h3, CMD_DAC, w[9:2], {w[1:0], 6'h00});
    check(39'(sq.size() + bq.size()), 39'h0);
    stop_test();
  end
endmodule
